// *** design/sap_seq.sv ***
// servo drive absolute position read and power stage sequencer
//
// How it works
// - reply is 32-bit position as hex
// - reply position also loads position command
// - servo-on power-up enables stage after 100 ms
// - ready rises only after stage enabled
// - link errors answered with an error code
// - stop release: stage 200 ms, ready +5 ms
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "sap_defs.svh"

module sap_seq #(
   parameter logic [31:0] SON_BASE_CYC = `SAP_SON_BASE_CYC,
   parameter logic [31:0] EM_BASE_CYC  = `SAP_EM_BASE_CYC,
   parameter logic [31:0] BASE_RDY_CYC = `SAP_BASE_RDY_CYC
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             clkEn,
   input  wire logic             servo_on_input,
   input  wire logic             forced_stop_two_input,
   input  wire logic             alarmCause,
   input  wire logic [31:0]      curPos,
   input  wire sap_pkg::sap_cmd_t linkCmd,
   input  wire logic [7:0]       regAddr,
   input  wire logic [31:0]      regWdata,
   input  wire logic             regWr,
   input  wire logic             regRd,
   output logic [31:0]           regRdata,
   output sap_pkg::sap_rsp_t     linkRsp,
   output logic [31:0]           posCmd,
   output logic                  posCmdLoad,
   output logic                  baseOn,
   output logic                  readyOut,
   output logic                  malfunction_output,
   output logic                  irq
);
   import sap_pkg::*;

   // ***********************************************
   // helper functions
   // ***********************************************
   // one nibble to its ascii hex character
   function automatic logic [7:0] hexChar(input logic [3:0] nib);
      hexChar = (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
   endfunction : hexChar

   // 32-bit word to eight hex characters, most significant first
   function automatic logic [63:0] hexWord(input logic [31:0] w);
      logic [63:0] t;
      t = 64'h0;
      for (int i = 0; i < 8; i++) begin
         t[i*8 +: 8] = hexChar(w[i*4 +: 4]);
      end
      hexWord = t;
   endfunction : hexWord

   // ***********************************************
   // state
   // ***********************************************
   sap_state_t                 state_q;
   sap_state_t                 state_d;
   logic [31:0]                cnt_q;
   logic [31:0]                cnt_d;
   logic [31:0]                ctrl_q;
   logic [`SAP_EV_W-1:0]       status_q;
   logic [`SAP_EV_W-1:0]       mask_q;
   logic [31:0]                lastPos_q;

   // ***********************************************
   // sequence decode
   // ***********************************************
   wire stopReleased = forced_stop_two_input;   // high means forced stop not active
   wire cntDone      = (cnt_q == 32'h0);
   wire cntRun       = ~cntDone;
   wire dropAll      = alarmCause | ~servo_on_input;

   // next state and delay load; servo-off and alarm win over everything
   always_comb begin
      state_d = state_q;
      cnt_d   = cntRun ? (cnt_q - 32'h1) : cnt_q;
      case (state_q)
         ST_OFF: begin
            if (!dropAll && stopReleased) begin
               state_d = ST_SONWAIT;
               cnt_d   = SON_BASE_CYC - 32'h1;
            end else if (!dropAll) begin
               state_d = ST_STOPPED;
            end
         end
         ST_SONWAIT: begin
            if (!stopReleased) begin
               state_d = ST_STOPPED;
            end else if (cntDone) begin
               state_d = ST_RDWAIT;
               cnt_d   = `SAP_PWR_RDY_CYC - 32'h1;
            end
         end
         ST_STOPPED: begin
            if (stopReleased) begin
               state_d = ST_EMWAIT;
               cnt_d   = EM_BASE_CYC - 32'h1;
            end
         end
         ST_EMWAIT: begin
            if (!stopReleased) begin
               state_d = ST_STOPPED;
            end else if (cntDone) begin
               state_d = ST_RDWAIT;
               cnt_d   = BASE_RDY_CYC - 32'h1;
            end
         end
         ST_RDWAIT: begin
            if (!stopReleased) begin
               state_d = ST_STOPPED;
            end else if (cntDone) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!stopReleased) begin
               state_d = ST_STOPPED;
            end
         end
         default: begin
            state_d = ST_OFF;
         end
      endcase
      if (dropAll) begin
         state_d = ST_OFF;
         cnt_d   = 32'h0;
      end
   end

   wire baseOn_d = (state_d == ST_RDWAIT) | (state_d == ST_RUN);
   wire ready_d  = (state_d == ST_RUN);

   // ***********************************************
   // command decode
   // ***********************************************
   // frames for other stations are ignored so only one drive answers
   wire forUs    = linkCmd.valid & (linkCmd.station == ctrl_q[7:0]);
   wire ansEn    = ctrl_q[`SAP_CTRL_ANS_BIT];
   wire take     = forUs & ansEn;
   wire badCmd   = linkCmd.cmd != `SAP_CMD_READ;
   wire badDno   = linkCmd.dataNo != `SAP_DNO_ABSPOS;
   wire goodRead = take & ~linkCmd.frameErr & ~badCmd & ~badDno;
   wire comErr   = take & ~goodRead;
   wire [7:0] errCode = linkCmd.frameErr ? `SAP_ERR_FRAME :
                        badCmd           ? `SAP_ERR_CMD   : `SAP_ERR_DATANO;

   // ***********************************************
   // register bus decode
   // ***********************************************
   wire selCtrl   = regAddr == `SAP_REG_CTRL;
   wire selStatus = regAddr == `SAP_REG_STATUS;
   wire selMask   = regAddr == `SAP_REG_MASK;
   wire selPos    = regAddr == `SAP_REG_LASTPOS;
   wire selState  = regAddr == `SAP_REG_STATE;
   wire [`SAP_EV_W-1:0] evSet = {ready_d & ~readyOut,
                                 alarmCause & ~malfunction_output,
                                 comErr,
                                 goodRead};
   wire [`SAP_EV_W-1:0] w1c   = (regWr & selStatus) ? regWdata[`SAP_EV_W-1:0] : '0;
   // a new event in the clearing cycle survives the clear
   wire [`SAP_EV_W-1:0] status_d = (status_q & ~w1c) | evSet;
   wire [31:0] stateWord = {24'h0, malfunction_output, readyOut, baseOn, 2'b00,
                            state_q == ST_RUN, state_q == ST_STOPPED,
                            state_q == ST_OFF};
   wire [31:0] rdMux = selCtrl   ? ctrl_q :
                       selStatus ? {28'h0, status_q} :
                       selMask   ? {28'h0, mask_q} :
                       selPos    ? lastPos_q :
                       selState  ? stateWord : 32'h0;   // unmapped reads zero

   // ***********************************************
   // sequence registers
   // ***********************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q            <= ST_OFF;
         cnt_q              <= 32'h0;
         baseOn             <= 1'b0;
         readyOut           <= 1'b0;
         malfunction_output <= 1'b0;
      end else if (clkEn) begin
         state_q            <= state_d;
         cnt_q              <= cnt_d;
         baseOn             <= baseOn_d;
         readyOut           <= ready_d;
         malfunction_output <= alarmCause;
      end
   end

   // ***********************************************
   // read answer and position command
   // ***********************************************
   // the sampled position is both the reply and the new command, same edge
   always_ff @(posedge mclk) begin
      if (rst) begin
         linkRsp    <= '0;
         posCmd     <= 32'h0;
         posCmdLoad <= 1'b0;
         lastPos_q  <= 32'h0;
      end else if (clkEn) begin
         linkRsp.valid   <= goodRead | comErr;
         linkRsp.isErr   <= comErr;
         linkRsp.errCode <= comErr ? errCode : 8'h00;
         linkRsp.hexText <= goodRead ? hexWord(curPos) : 64'h0;
         posCmdLoad      <= goodRead;
         if (goodRead) begin
            posCmd    <= curPos;
            lastPos_q <= curPos;
         end
      end
   end

   // ***********************************************
   // software registers and interrupt
   // ***********************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_q   <= `SAP_CTRL_RST;
         status_q <= '0;
         mask_q   <= '0;
         regRdata <= 32'h0;
         irq      <= 1'b0;
      end else if (clkEn) begin
         if (regWr && selCtrl) begin
            ctrl_q <= {23'h0, regWdata[8:0]};
         end
         if (regWr && selMask) begin
            mask_q <= regWdata[`SAP_EV_W-1:0];
         end
         status_q <= status_d;
         regRdata <= regRd ? rdMux : 32'h0;
         irq      <= |(status_d & mask_q);
      end
   end

endmodule : sap_seq

// *** design/sap_defs.svh ***
// register map, field positions, reset values and timing counts of the position sequencer
`ifndef SAP_DEFS_SVH
`define SAP_DEFS_SVH

// ***********************************************
// clock and sequence timing
// ***********************************************
`define SAP_MCLK_KHZ       200000
`define SAP_SON_BASE_MS    100
`define SAP_EM_BASE_MS     200
`define SAP_BASE_RDY_MS    5
`define SAP_SON_BASE_CYC   (`SAP_SON_BASE_MS * `SAP_MCLK_KHZ)
`define SAP_EM_BASE_CYC    (`SAP_EM_BASE_MS * `SAP_MCLK_KHZ)
`define SAP_BASE_RDY_CYC   (`SAP_BASE_RDY_MS * `SAP_MCLK_KHZ)
`define SAP_PWR_RDY_CYC    32'h0000_0001

// ***********************************************
// serial command values
// ***********************************************
`define SAP_CMD_READ       8'h02
`define SAP_DNO_ABSPOS     8'h91
`define SAP_ERR_FRAME      8'h41
`define SAP_ERR_CMD        8'h42
`define SAP_ERR_DATANO     8'h43

// ***********************************************
// register offsets and fields
// ***********************************************
`define SAP_REG_CTRL       8'h00
`define SAP_REG_STATUS     8'h04
`define SAP_REG_MASK       8'h08
`define SAP_REG_LASTPOS    8'h0c
`define SAP_REG_STATE      8'h10
`define SAP_CTRL_RST       32'h0000_0100
`define SAP_CTRL_ANS_BIT   8
`define SAP_EV_READ        0
`define SAP_EV_COMERR      1
`define SAP_EV_ALARM       2
`define SAP_EV_READY       3
`define SAP_EV_W           4

`endif

// *** design/sap_pkg.sv ***
// types shared by the position sequencer and its users
package sap_pkg;

   // decoded frame from the serial link layer
   typedef struct packed {
      logic       valid;
      logic       frameErr;
      logic [7:0] station;
      logic [7:0] cmd;
      logic [7:0] dataNo;
   } sap_cmd_t;

   // answer handed back to the link layer
   typedef struct packed {
      logic        valid;
      logic        isErr;
      logic [7:0]  errCode;
      logic [63:0] hexText;
   } sap_rsp_t;

   // one-hot sequence states
   typedef enum logic [5:0] {
      ST_OFF     = 6'b000001,
      ST_SONWAIT = 6'b000010,
      ST_STOPPED = 6'b000100,
      ST_EMWAIT  = 6'b001000,
      ST_RDWAIT  = 6'b010000,
      ST_RUN     = 6'b100000
   } sap_state_t;

endpackage : sap_pkg

// *** sim/sap_seq_sva.sv ***
// concurrent checks on the position sequencer ports
`timescale 1ns/1ps
`include "sap_defs.svh"
module sap_seq_sva #(
   parameter logic [31:0] SON_BASE_CYC = 8,
   parameter logic [31:0] EM_BASE_CYC  = 12,
   parameter logic [31:0] BASE_RDY_CYC = 4
) (
   input wire logic              mclk,
   input wire logic              rst,
   input wire logic              clkEn,
   input wire logic              servo_on_input,
   input wire logic              forced_stop_two_input,
   input wire logic              alarmCause,
   input wire logic [31:0]       curPos,
   input wire sap_pkg::sap_cmd_t linkCmd,
   input wire sap_pkg::sap_rsp_t linkRsp,
   input wire logic [31:0]       posCmd,
   input wire logic              posCmdLoad,
   input wire logic              baseOn,
   input wire logic              readyOut,
   input wire logic              malfunction_output
);
   import sap_pkg::*;
   default clocking @(posedge mclk); endclocking
   // a frozen cycle stretches every window, so those attempts are dropped
   default disable iff (rst || !clkEn);
   // windows fit the shortened counts 8, 12 and 4 only
   wire logic upOk = servo_on_input && forced_stop_two_input && !alarmCause;
   wire logic good = linkRsp.valid && !linkRsp.isErr;
   sequence sHoldOff; (!baseOn)[*8]; endsequence
   sequence sRdyLag; $rose(baseOn) ##1 (!readyOut)[*2] ##[1:4] readyOut; endsequence
   chk_rsp_cause: assert property ((linkRsp.valid || posCmdLoad) |-> $past(linkCmd.valid))
      else $error("answer without a command");
   chk_good_decode: assert property (good |-> $past(linkCmd.dataNo) == `SAP_DNO_ABSPOS)
      else $error("good answer to a wrong data number");
   chk_pos_load: assert property (good |-> posCmdLoad && posCmd == $past(curPos))
      else $error("position command not loaded with reported value");
   chk_err_frame: assert property (linkRsp.valid && $past(linkCmd.frameErr)
      |-> linkRsp.isErr && linkRsp.errCode == `SAP_ERR_FRAME) else $error("bad frame code");
   chk_rdy_base: assert property ($rose(readyOut) |-> $past(baseOn) && baseOn)
      else $error("ready before output stage");
   chk_son_delay: assert property ($rose(servo_on_input) && upOk
      |-> sHoldOff ##[1:3] baseOn ##[1:2] readyOut) else $error("power-on timing wrong");
   chk_em_release: assert property ($rose(forced_stop_two_input) && upOk
      |-> sHoldOff ##[3:7] sRdyLag) else $error("stop release timing wrong");
   chk_off_prio: assert property ((!servo_on_input || alarmCause) |=> !baseOn && !readyOut)
      else $error("stage still on after servo off or alarm");
   chk_malf_copy: assert property (!$past(rst) && $past(clkEn)
      |-> malfunction_output == $past(alarmCause))
      else $error("malfunction output does not follow alarm");
   // enable low must hold baseOn, readyOut, posCmd and malfunction_output where they stand
   chk_freeze_hold: assert property (disable iff (rst) !clkEn |=> $stable(baseOn)
      && $stable(readyOut) && $stable(posCmd) && $stable(malfunction_output))
      else $error("state moved while clock enable low");
endmodule : sap_seq_sva
bind sap_seq sap_seq_sva #(.SON_BASE_CYC(SON_BASE_CYC), .EM_BASE_CYC(EM_BASE_CYC),
   .BASE_RDY_CYC(BASE_RDY_CYC)) i_sap_seq_sva (.*);

// *** sim/sap_host.sv ***
// host controller model issuing position reads with retry and time-out
`timescale 1ns/1ps
`include "sap_defs.svh"
module sap_host #(
   parameter int RETRIES = 2,
   parameter int TMO     = 6
) (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              go,
   input  wire logic [1:0]        kind,
   input  wire logic [7:0]        stn,
   input  wire sap_pkg::sap_rsp_t linkRsp,
   output sap_pkg::sap_cmd_t      linkCmd,
   output logic                   done,
   output logic                   fail
);
   import sap_pkg::*;
   logic       busy;
   logic [3:0] tries, wt;
   // silence or an error answer both count as a failed try
   wire logic again = busy && (linkRsp.valid ? linkRsp.isErr : wt == TMO);
   wire logic send  = (go && !busy) || (again && tries != RETRIES);
   always @(posedge mclk) begin
      done    <= 1'b0;
      linkCmd <= '0;
      wt      <= wt + 4'h1;
      if (rst) begin
         busy <= 1'b0;
         fail <= 1'b0;
      end else if (send) begin
         // kinds 1..3 break the frame on purpose: frame, command, data number
         linkCmd <= '{1'b1, kind == 2'd1, stn, kind == 2'd2 ? 8'h03 : `SAP_CMD_READ,
                      kind == 2'd3 ? 8'h90 : `SAP_DNO_ABSPOS};
         busy  <= 1'b1;
         wt    <= 4'h0;
         tries <= busy ? tries + 4'h1 : 4'h0;
         fail  <= 1'b0;
      end else if (busy && (again || linkRsp.valid)) begin
         busy <= 1'b0;
         done <= 1'b1;
         fail <= again;
      end
   end
endmodule : sap_host

// *** sim/servo_abs_position_serial_read_tb.sv ***
// self-checking bench for the position sequencer
`timescale 1ns/1ps
`include "sap_defs.svh"
module servo_abs_position_serial_read_tb;
   import sap_pkg::*;
   logic        mclk = 1'b0, rst = 1'b1, servoOn = 1'b0, stopRel = 1'b1, alarm = 1'b0;
   logic        regWr = 1'b0, regRd = 1'b0, go = 1'b0, clkEn = 1'b1;
   logic [1:0]  kind = 2'd0;
   logic [7:0]  regAddr = 8'h0, stn = 8'h0;
   logic [31:0] curPos = 32'h0, regWdata = 32'h0, regRdata, posCmd, rdv;
   logic        posCmdLoad, baseOn, readyOut, malf, irq, done, fail;
   sap_cmd_t    linkCmd;
   sap_rsp_t    linkRsp, lastRsp;
   int          mismatches = 0, n_compared = 0, nRsp = 0, n0, i, seed = 87699;
   always #2.5 mclk = ~mclk;
   sap_seq #(.SON_BASE_CYC(8), .EM_BASE_CYC(12), .BASE_RDY_CYC(4)) i_sap_seq (
      .mclk(mclk), .rst(rst), .clkEn(clkEn), .servo_on_input(servoOn),
      .forced_stop_two_input(stopRel), .alarmCause(alarm), .curPos(curPos),
      .linkCmd(linkCmd), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .linkRsp(linkRsp), .posCmd(posCmd),
      .posCmdLoad(posCmdLoad), .baseOn(baseOn), .readyOut(readyOut),
      .malfunction_output(malf), .irq(irq));
   sap_host #(.RETRIES(2), .TMO(6)) i_sap_host (.mclk(mclk), .rst(rst), .go(go),
      .kind(kind), .stn(stn), .linkRsp(linkRsp), .linkCmd(linkCmd), .done(done), .fail(fail));
   // keep the latest answer and a running count of answers
   always @(posedge mclk) if (linkRsp.valid === 1'b1) begin
      lastRsp <= linkRsp;
      nRsp    <= nRsp + 1;
   end
   function automatic logic [63:0] hexOf(input logic [31:0] p);
      logic [3:0] n;
      for (int j = 0; j < 8; j++) begin
         n = p[4*j +: 4];
         hexOf[8*j +: 8] = n < 4'ha ? 8'h30 + n : 8'h37 + n;
      end
   endfunction : hexOf
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge mclk);
      regWr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      rdv = regRdata;
   endtask : rd
   // bounded waits: settle one step past each edge before looking
   task automatic hostRead(input logic [1:0] k);
      @(posedge mclk);
      kind <= k;
      go   <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      for (i = 0; i < 80 && done !== 1'b1; i++) @(posedge mclk) #1;
      check("done", done, 1'b1);
   endtask : hostRead
   task automatic waitRdy;
      for (i = 0; i < 60 && readyOut !== 1'b1; i++) @(posedge mclk) #1;
      check("ready", readyOut, 1'b1);
   endtask : waitRdy
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // run is a few hundred cycles; the 20000-cycle limit cuts a hang
   initial begin
      #100000;
      mismatches++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rd(`SAP_REG_CTRL);
      check("ctrl", rdv, `SAP_CTRL_RST);
      rd(8'h20);
      check("hole", rdv, 32'h0);
      wr(`SAP_REG_MASK, 32'h1);
      @(posedge mclk) servoOn <= 1'b1;
      waitRdy();
      rd(`SAP_REG_STATE);
      check("state", rdv, 32'h64);
      $display("power-on done");
      for (int k = 0; k < 5; k++) begin
         @(posedge mclk) curPos <= k == 0 ? 32'h0 : k == 1 ? 32'hffff_ffff : $random(seed);
         hostRead(2'd0);
         check("poscmd", posCmd, curPos);
         check("hex", lastRsp.hexText, hexOf(curPos));
         check("irq", irq, 1'b1);
         rd(`SAP_REG_LASTPOS);
         check("lastpos", rdv, curPos);
         wr(`SAP_REG_STATUS, 32'h1);
         check("irq clear", irq, 1'b0);
      end
      $display("reads done");
      // freeze: a write while the enable is low must be lost
      @(posedge mclk) clkEn <= 1'b0;
      wr(`SAP_REG_MASK, 32'hf);
      @(posedge mclk) clkEn <= 1'b1;
      rd(`SAP_REG_MASK);
      check("frozen mask", rdv, 32'h1);
      check("frozen ready", readyOut, 1'b1);
      for (int k = 1; k < 4; k++) begin
         n0 = nRsp;
         hostRead(2'(k));
         check("fail", fail, 1'b1);
         check("code", lastRsp.errCode, 8'h40 + k);
         check("tries", nRsp - n0, 3);
      end
      wr(`SAP_REG_CTRL, 32'h105);
      n0 = nRsp;
      hostRead(2'd0);
      check("ignored", nRsp - n0, 0);
      check("timeout", fail, 1'b1);
      @(posedge mclk) stn <= 8'h05;
      hostRead(2'd0);
      check("station", fail, 1'b0);
      // answers disabled: right station, still no reply
      wr(`SAP_REG_CTRL, 32'h5);
      n0 = nRsp;
      hostRead(2'd0);
      check("muted", nRsp - n0, 0);
      wr(`SAP_REG_CTRL, 32'h105);
      $display("errors done");
      @(posedge mclk) stopRel <= 1'b0;
      @(posedge mclk) curPos <= $random(seed);
      hostRead(2'd0);
      check("stop base", baseOn, 1'b0);
      check("stop read", posCmd, curPos);
      @(posedge mclk) stopRel <= 1'b1;
      repeat (8) @(posedge mclk) #1;
      check("release wait", baseOn, 1'b0);
      waitRdy();
      @(posedge mclk) alarm <= 1'b1;
      repeat (2) @(posedge mclk) #1;
      check("malf", malf, 1'b1);
      check("alarm base", baseOn, 1'b0);
      @(posedge mclk) servoOn <= 1'b0;
      @(posedge mclk) alarm <= 1'b0;
      @(posedge mclk) servoOn <= 1'b1;
      waitRdy();
      @(posedge mclk) curPos <= $random(seed);
      hostRead(2'd0);
      check("reacquire", posCmd, curPos);
      $display("sequence done");
      wrap_up();
   end
endmodule : servo_abs_position_serial_read_tb
